// [hw/scg_pkg.sv]
// Shared constants and types of the serial port clock generation block
package scg_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int         SCG_ADDR_W       = 8;
   localparam logic [7:0] SCG_OFS_DATA     = 8'h00;
   localparam logic [7:0] SCG_OFS_CTRL_A   = 8'h04;
   localparam logic [7:0] SCG_OFS_CTRL_C   = 8'h08;
   localparam logic [7:0] SCG_OFS_DIV_LOW  = 8'h0c;
   localparam logic [7:0] SCG_OFS_DIV_HIGH = 8'h10;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SCG_A_RXC  = 7;
   localparam int SCG_A_TXC  = 6;
   localparam int SCG_A_DRE  = 5;
   localparam int SCG_A_FE   = 4;
   localparam int SCG_A_DOR  = 3;
   localparam int SCG_A_PE   = 2;
   localparam int SCG_A_DS   = 0;
   localparam int SCG_C_POL  = 0;
   localparam int SCG_C_DIR  = 1;
   localparam int SCG_C_TXEN = 2;
   localparam int SCG_C_RXEN = 3;
   localparam int SCG_C_PAR  = 4;
   localparam int SCG_C_SYNC = 6;
   localparam int SCG_E_FE   = 8;
   localparam int SCG_E_PE   = 9;

   // ---------------------------------------------------------------
   // Codes and counts
   // ---------------------------------------------------------------
   localparam logic [1:0] SCG_PAR_ODD     = 2'h3;
   localparam logic [1:0] SCG_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SCG_RESP_SLVERR = 2'h2;
   localparam logic [3:0] SCG_LAST_NORMAL = 4'hf;
   localparam logic [3:0] SCG_LAST_DOUBLE = 4'h7;
   localparam logic [3:0] SCG_MID_NORMAL  = 4'h7;
   localparam logic [3:0] SCG_MID_DOUBLE  = 4'h3;
   localparam logic [2:0] SCG_LAST_BIT    = 3'h7;
   localparam logic [1:0] SCG_RX_DEPTH    = 2'h2;
   localparam logic [3:0] SCG_DIV_HIGH_W  = 4'hf;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} scg_tx_st_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} scg_rx_st_t;

   typedef struct packed {
      logic             aw_full;
      logic [7:0]       aw_addr;
      logic             w_full;
      logic [31:0]      w_data;
      logic [3:0]       w_strb;
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic [11:0]      div;
      logic [11:0]      cnt;
      logic             ds;
      logic             sync;
      logic             dir;
      logic             pol;
      logic             tx_en;
      logic             rx_en;
      logic [1:0]       par_mode;
      logic             xs1;
      logic             xs2;
      logic             xprev;
      logic             xck_o;
      logic             xck_oe_n;
      logic [3:0]       tx_pre;
      scg_tx_st_t       tx_st;
      logic [7:0]       tx_buf;
      logic             tx_buf_full;
      logic [7:0]       tx_sh;
      logic [2:0]       tx_bit;
      logic             tx_par;
      logic             tx_line;
      scg_rx_st_t       rx_st;
      logic [3:0]       rx_ph;
      logic [7:0]       rx_sh;
      logic [2:0]       rx_bit;
      logic             rx_par;
      logic             rx_perr;
      logic [1:0][9:0]  fifo;
      logic [1:0]       fcnt;
      logic             ovr;
      logic             txc;
      logic             dre;
      logic             rxc;
   } scg_state_t;

endpackage

// [hw/scg_top.sv]
// Serial port with baud generator, clock modes and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

module scg_top (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [scg_pkg::SCG_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [scg_pkg::SCG_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   output logic                               serial_tx_pin,
   input  wire logic                          serial_rx_pin,
   input  wire logic                          transfer_clock_pin_in,
   output logic                               transfer_clock_pin_out,
   output logic                               transfer_clock_pin_oe_n,
   output logic                               irq_tx_complete,
   output logic                               irq_data_empty,
   output logic                               irq_rx_complete
);

   localparam scg_pkg::scg_state_t RST_VAL = '{tx_line: 1'b1, xck_oe_n: 1'b1, dre: 1'b1,
                                              tx_st: scg_pkg::TX_IDLE,
                                              rx_st: scg_pkg::RX_IDLE, default: '0};

   scg_pkg::scg_state_t q;
   scg_pkg::scg_state_t d;
   logic       wr_fire;
   logic       rd_fire;
   logic       wr_low;
   logic       wr_data;
   logic       txc_clr;
   logic       rd_pop;
   logic       ovr_clr;
   logic       tick;
   logic       master;
   logic       slave;
   logic [3:0] last;
   logic [3:0] mid;
   logic       xrise;
   logic       xfall;
   logic       chg;
   logic       smp;
   logic       tx_step;
   logic       rx_ev;
   logic       odd;
   logic       rx_push;
   logic [9:0] rx_entry;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d        = q;
      wr_low   = 1'b0;
      wr_data  = 1'b0;
      txc_clr  = 1'b0;
      rd_pop   = 1'b0;
      ovr_clr  = 1'b0;
      rx_push  = 1'b0;
      rx_entry = '0;
      wr_fire  = q.aw_full && q.w_full && !q.bvalid;
      rd_fire  = s_axi_arvalid && q.arready;
      if (s_axi_awvalid && q.awready) begin
         d.aw_full = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_full = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (wr_fire) begin
         d.aw_full = 1'b0;
         d.w_full  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = scg_pkg::SCG_RESP_OKAY;
         case (q.aw_addr)
            scg_pkg::SCG_OFS_DATA: begin
               wr_data = q.w_strb[0];
            end
            scg_pkg::SCG_OFS_CTRL_A: begin
               if (q.w_strb[0]) begin
                  d.ds    = q.w_data[scg_pkg::SCG_A_DS];
                  txc_clr = q.w_data[scg_pkg::SCG_A_TXC];
               end
            end
            scg_pkg::SCG_OFS_CTRL_C: begin
               if (q.w_strb[0]) begin
                  d.pol      = q.w_data[scg_pkg::SCG_C_POL];
                  d.dir      = q.w_data[scg_pkg::SCG_C_DIR];
                  d.tx_en    = q.w_data[scg_pkg::SCG_C_TXEN];
                  d.rx_en    = q.w_data[scg_pkg::SCG_C_RXEN];
                  d.par_mode = q.w_data[scg_pkg::SCG_C_PAR +: 2];
                  d.sync     = q.w_data[scg_pkg::SCG_C_SYNC];
               end
            end
            scg_pkg::SCG_OFS_DIV_LOW: begin
               if (q.w_strb[0]) begin
                  d.div[7:0] = q.w_data[7:0];
                  wr_low     = 1'b1;
               end
            end
            scg_pkg::SCG_OFS_DIV_HIGH: begin
               if (q.w_strb[0]) begin
                  d.div[11:8] = q.w_data[3:0] & scg_pkg::SCG_DIV_HIGH_W;
               end
            end
            default: begin
               d.bresp = scg_pkg::SCG_RESP_SLVERR;
            end
         endcase
      end
      if (rd_fire) begin
         d.rvalid = 1'b1;
         d.rresp  = scg_pkg::SCG_RESP_OKAY;
         d.rdata  = '0;
         case (s_axi_araddr)
            scg_pkg::SCG_OFS_DATA: begin
               d.rdata[7:0] = q.fifo[0][7:0];
               rd_pop       = (q.fcnt != 2'h0);
               ovr_clr      = 1'b1;
            end
            scg_pkg::SCG_OFS_CTRL_A: begin
               d.rdata[scg_pkg::SCG_A_RXC] = q.rxc;
               d.rdata[scg_pkg::SCG_A_TXC] = q.txc;
               d.rdata[scg_pkg::SCG_A_DRE] = q.dre;
               d.rdata[scg_pkg::SCG_A_FE]  = q.fifo[0][scg_pkg::SCG_E_FE] && q.rxc;
               d.rdata[scg_pkg::SCG_A_DOR] = q.ovr;
               d.rdata[scg_pkg::SCG_A_PE]  = q.fifo[0][scg_pkg::SCG_E_PE] && q.rxc;
               d.rdata[scg_pkg::SCG_A_DS]  = q.ds;
            end
            scg_pkg::SCG_OFS_CTRL_C: begin
               d.rdata[scg_pkg::SCG_C_POL]        = q.pol;
               d.rdata[scg_pkg::SCG_C_DIR]        = q.dir;
               d.rdata[scg_pkg::SCG_C_TXEN]       = q.tx_en;
               d.rdata[scg_pkg::SCG_C_RXEN]       = q.rx_en;
               d.rdata[scg_pkg::SCG_C_PAR +: 2]   = q.par_mode;
               d.rdata[scg_pkg::SCG_C_SYNC]       = q.sync;
            end
            scg_pkg::SCG_OFS_DIV_LOW: begin
               d.rdata[7:0] = q.div[7:0];
            end
            scg_pkg::SCG_OFS_DIV_HIGH: begin
               d.rdata[3:0] = q.div[11:8];
            end
            default: begin
               d.rresp = scg_pkg::SCG_RESP_SLVERR;
            end
         endcase
      end
      d.awready = !d.aw_full;
      d.wready  = !d.w_full;
      d.arready = !d.rvalid;

      // ----------------------------------------------------------------
      // Baud generator and clock modes
      // ----------------------------------------------------------------
      tick  = (q.cnt == 12'h000);
      d.cnt = (tick || wr_low) ? d.div : q.cnt - 12'h001;
      master = q.sync && q.dir;
      slave  = q.sync && !q.dir;
      last   = q.ds ? scg_pkg::SCG_LAST_DOUBLE : scg_pkg::SCG_LAST_NORMAL;
      mid    = q.ds ? scg_pkg::SCG_MID_DOUBLE : scg_pkg::SCG_MID_NORMAL;
      odd    = (q.par_mode == scg_pkg::SCG_PAR_ODD);
      d.xs1   = transfer_clock_pin_in;
      d.xs2   = q.xs1;
      d.xprev = q.xs2;
      d.xck_o    = master ? (q.xck_o ^ tick) : 1'b0;
      d.xck_oe_n = !master;
      xrise = master ? (tick && !q.xck_o) : (slave && q.xs2 && !q.xprev);
      xfall = master ? (tick && q.xck_o) : (slave && !q.xs2 && q.xprev);
      chg   = q.pol ? xfall : xrise;
      smp   = q.pol ? xrise : xfall;
      tx_step = q.sync ? chg : (tick && q.tx_pre >= last);
      if (q.sync) begin
         d.tx_pre = 4'h0;
      end else if (tick) begin
         d.tx_pre = (q.tx_pre >= last) ? 4'h0 : q.tx_pre + 4'h1;
      end

      // ----------------------------------------------------------------
      // Transmitter
      // ----------------------------------------------------------------
      if (wr_data && !q.tx_buf_full) begin
         d.tx_buf      = q.w_data[7:0];
         d.tx_buf_full = 1'b1;
      end
      if (txc_clr) begin
         d.txc = 1'b0;
      end
      if (!q.tx_en) begin
         d.tx_st   = scg_pkg::TX_IDLE;
         d.tx_line = 1'b1;
      end else if (tx_step) begin
         case (q.tx_st)
            scg_pkg::TX_IDLE, scg_pkg::TX_STOP: begin
               if (q.tx_buf_full) begin
                  d.tx_sh       = q.tx_buf;
                  d.tx_buf_full = 1'b0;
                  d.tx_par      = ^q.tx_buf ^ odd;
                  d.tx_line     = 1'b0;
                  d.tx_st       = scg_pkg::TX_START;
               end else begin
                  d.tx_line = 1'b1;
                  d.tx_st   = scg_pkg::TX_IDLE;
                  d.txc     = q.txc || (q.tx_st == scg_pkg::TX_STOP);
               end
            end
            scg_pkg::TX_START: begin
               d.tx_line = q.tx_sh[0];
               d.tx_sh   = q.tx_sh >> 1;
               d.tx_bit  = 3'h0;
               d.tx_st   = scg_pkg::TX_DATA;
            end
            scg_pkg::TX_DATA: begin
               if (q.tx_bit == scg_pkg::SCG_LAST_BIT) begin
                  d.tx_line = q.par_mode[1] ? q.tx_par : 1'b1;
                  d.tx_st   = q.par_mode[1] ? scg_pkg::TX_PAR : scg_pkg::TX_STOP;
               end else begin
                  d.tx_line = q.tx_sh[0];
                  d.tx_sh   = q.tx_sh >> 1;
                  d.tx_bit  = q.tx_bit + 3'h1;
               end
            end
            scg_pkg::TX_PAR: begin
               d.tx_line = 1'b1;
               d.tx_st   = scg_pkg::TX_STOP;
            end
            default: begin
               d.tx_st = scg_pkg::TX_IDLE;
            end
         endcase
      end
      d.dre = !d.tx_buf_full;

      // ----------------------------------------------------------------
      // Receiver
      // ----------------------------------------------------------------
      rx_ev = q.sync ? smp : (tick && q.rx_ph == mid);
      if (!q.sync && tick && q.rx_st != scg_pkg::RX_IDLE) begin
         d.rx_ph = (q.rx_ph >= last) ? 4'h0 : q.rx_ph + 4'h1;
      end
      if (!q.rx_en) begin
         d.rx_st = scg_pkg::RX_IDLE;
      end else begin
         case (q.rx_st)
            scg_pkg::RX_IDLE: begin
               if (!serial_rx_pin && (q.sync ? smp : tick)) begin
                  d.rx_st   = q.sync ? scg_pkg::RX_DATA : scg_pkg::RX_START;
                  d.rx_ph   = 4'h0;
                  d.rx_bit  = 3'h0;
                  d.rx_par  = 1'b0;
                  d.rx_perr = 1'b0;
               end
            end
            scg_pkg::RX_START: begin
               if (rx_ev) begin
                  d.rx_st = serial_rx_pin ? scg_pkg::RX_IDLE : scg_pkg::RX_DATA;
               end
            end
            scg_pkg::RX_DATA: begin
               if (rx_ev) begin
                  d.rx_sh  = {serial_rx_pin, q.rx_sh[7:1]};
                  d.rx_par = q.rx_par ^ serial_rx_pin;
                  d.rx_bit = q.rx_bit + 3'h1;
                  if (q.rx_bit == scg_pkg::SCG_LAST_BIT) begin
                     d.rx_st = q.par_mode[1] ? scg_pkg::RX_PAR : scg_pkg::RX_STOP;
                  end
               end
            end
            scg_pkg::RX_PAR: begin
               if (rx_ev) begin
                  d.rx_perr = serial_rx_pin ^ q.rx_par ^ odd;
                  d.rx_st   = scg_pkg::RX_STOP;
               end
            end
            scg_pkg::RX_STOP: begin
               if (rx_ev) begin
                  rx_push  = 1'b1;
                  rx_entry = {q.rx_perr, !serial_rx_pin, q.rx_sh};
                  d.rx_st  = scg_pkg::RX_IDLE;
               end
            end
            default: begin
               d.rx_st = scg_pkg::RX_IDLE;
            end
         endcase
      end
      if (ovr_clr) begin
         d.ovr = 1'b0;
      end
      if (rd_pop) begin
         d.fifo[0] = q.fifo[1];
         d.fcnt    = q.fcnt - 2'h1;
      end
      if (rx_push) begin
         if (d.fcnt == scg_pkg::SCG_RX_DEPTH) begin
            d.ovr = 1'b1;
         end else begin
            d.fifo[d.fcnt[0]] = rx_entry;
            d.fcnt            = d.fcnt + 2'h1;
         end
      end
      d.rxc = (d.fcnt != 2'h0);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RST_VAL;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready           = q.awready;
   assign s_axi_wready            = q.wready;
   assign s_axi_bresp             = q.bresp;
   assign s_axi_bvalid            = q.bvalid;
   assign s_axi_arready           = q.arready;
   assign s_axi_rdata             = q.rdata;
   assign s_axi_rresp             = q.rresp;
   assign s_axi_rvalid            = q.rvalid;
   assign serial_tx_pin           = q.tx_line;
   assign transfer_clock_pin_out  = q.xck_o;
   assign transfer_clock_pin_oe_n = q.xck_oe_n;
   assign irq_tx_complete         = q.txc;
   assign irq_data_empty          = q.dre;
   assign irq_rx_complete         = q.rxc;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [4:0] tk_cnt_q;
   logic       tk_ok_q;

   // Tick count is trusted only after one async bit step with no mode change
   always_ff @(posedge aclk) begin
      if (!aresetn || tx_step) begin
         tk_cnt_q <= 5'h00;
      end else if (tick) begin
         tk_cnt_q <= tk_cnt_q + 5'h01;
      end
      tk_ok_q <= aresetn && !q.sync && (d.ds == q.ds) && (tk_ok_q || tx_step);
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_BAUD_RELOAD: assert property (tick && !wr_fire |=> q.cnt == $past(q.div))
      else $error("baud counter did not reload divisor");
   AST_BAUD_TICK: assert property (q.cnt == 12'h001 && !wr_fire |=> tick)
      else $error("baud tick missing after count one");
   AST_TX_DIVIDE: assert property (!q.sync && tx_step && tk_ok_q
      |-> tk_cnt_q == {1'b0, last})
      else $error("async bit clock not 16 or 8 ticks");
   AST_MASTER_CLK: assert property (master && tick ##1 master |-> q.xck_o != $past(q.xck_o))
      else $error("master clock did not toggle on tick");
   AST_SLAVE_LAT: assert property (slave && $rose(transfer_clock_pin_in) ##1
      (slave && transfer_clock_pin_in) |-> ##1 (q.xs2 && !q.xprev))
      else $error("slave edge not seen two cycles later");
   AST_PIN_DIR: assert property (q.sync && q.dir |=> !transfer_clock_pin_oe_n)
      else $error("master does not drive clock pin");
   AST_POL_EDGE: assert property (master && !q.pol && q.tx_en && tx_step
      |=> $rose(transfer_clock_pin_out))
      else $error("data change not on rising clock edge");
   AST_BACK2BACK: assert property (q.tx_en && tx_step && q.tx_st == scg_pkg::TX_STOP
      && q.tx_buf_full |=> q.tx_st == scg_pkg::TX_START && !serial_tx_pin)
      else $error("gap between buffered frames");
   AST_OVERRUN: assert property (q.rx_en && rx_ev && q.rx_st == scg_pkg::RX_STOP
      && q.fcnt == scg_pkg::SCG_RX_DEPTH && !rd_fire |=> q.ovr)
      else $error("overrun not flagged");
   AST_TX_DONE: assert property (q.tx_en && tx_step && q.tx_st == scg_pkg::TX_STOP
      && !q.tx_buf_full |=> irq_tx_complete)
      else $error("transmit complete not raised");

   COV_BACK2BACK: cover property (q.tx_en && tx_step && q.tx_st == scg_pkg::TX_STOP
      && q.tx_buf_full);
   COV_OVERRUN: cover property (q.rx_en && rx_push && q.ovr == 1'b0 ##1 q.ovr);
   COV_SLAVE_RX: cover property (slave && rx_ev && q.rx_st == scg_pkg::RX_STOP);

endmodule
`default_nettype wire

// [tb/scg_partner.sv]
// Remote echo transceiver with a gated slave clock
`timescale 1ns/1ps
`default_nettype none
module scg_partner (
   input  wire logic aclk,
   input  wire logic tx,
   input  wire logic clk_en,
   input  wire logic idle_lvl,
   output logic      rx,
   output logic      xck
);
   int n = 0;
   assign rx = tx;
   // Clock at an eighth of aclk, idle level while clk_en is low
   always @(posedge aclk) begin
      n <= (n + 1) % 4;
      xck <= !clk_en ? idle_lvl : ((n == 3) ? !xck : xck);
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the serial port clock block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {logic [7:0] a, w, q; logic [1:0] s;} scg_row_t;
   logic        aclk = 0, aresetn = 0, cen = 0, idl = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_tx_pin, serial_rx_pin;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        transfer_clock_pin_in, transfer_clock_pin_out, transfer_clock_pin_oe_n;
   logic        irq_tx_complete, irq_data_empty, irq_rx_complete;
   int          mismatches = 0, check_count = 0;
   scg_row_t    rows [4] = '{'{8'h04, 8'h01, 8'h21, 2'h0}, '{8'h04, 8'h00, 8'h20, 2'h0},
                             '{8'h08, 8'h3c, 8'h3c, 2'h0}, '{8'h14, 8'h55, 8'h00, 2'h2}};
   scg_top dut_u (.*);
   scg_partner peer_u (.aclk, .tx(serial_tx_pin), .clk_en(cen), .idle_lvl(idl),
                       .rx(serial_rx_pin), .xck(transfer_clock_pin_in));
   initial forever #20 aclk = ~aclk;
   task automatic cmp(input logic [31:0] g, e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      q = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask
   // Send one byte, time its first high run, read the echo
   task automatic frame(input logic [7:0] c, a, d, input int hi);
      int n;
      logic [1:0] r;
      logic [31:0] q;
      n = 0;
      wr(scg_pkg::SCG_OFS_CTRL_A, a | 8'h40, r);
      wr(scg_pkg::SCG_OFS_CTRL_C, c, r);
      wr(scg_pkg::SCG_OFS_DATA, d, r);
      while (serial_tx_pin) @(posedge aclk);
      while (!serial_tx_pin) @(posedge aclk);
      while (serial_tx_pin) begin
         @(posedge aclk);
         n++;
      end
      if (hi > 0) cmp(n, hi);
      while (!irq_rx_complete) @(posedge aclk);
      rd(scg_pkg::SCG_OFS_DATA, q, r);
      cmp(q, d);
      repeat (32) @(posedge aclk);
      cmp({irq_tx_complete, r}, 3'h4);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #2000000;
      mismatches++;
      end_of_test();
   end
   initial begin
      logic [1:0] r;
      logic [31:0] q;
      logic b;
      int n;
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      cmp({irq_data_empty, serial_tx_pin, transfer_clock_pin_oe_n}, 3'h7);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w, r);
         cmp(r, rows[i].s);
         rd(rows[i].a, q, r);
         cmp(q, rows[i].q);
      end
      wr(scg_pkg::SCG_OFS_DIV_LOW, 2, r);
      wr(scg_pkg::SCG_OFS_CTRL_C, 8'h42, r);
      cmp(transfer_clock_pin_oe_n, 0);
      b = transfer_clock_pin_out;
      while (transfer_clock_pin_out === b) @(posedge aclk);
      b = transfer_clock_pin_out;
      n = 0;
      while (transfer_clock_pin_out === b) begin
         @(posedge aclk);
         n++;
      end
      cmp(n, 3);
      wr(scg_pkg::SCG_OFS_DIV_LOW, 1, r);
      frame(8'h0c, 8'h00, 8'h3c, 128);
      cmp({transfer_clock_pin_oe_n, transfer_clock_pin_out}, 2'h2);
      frame(8'h0c, 8'h01, 8'h3c, 64);
      frame(8'h3c, 8'h00, 8'ha5, 0);
      frame(8'h4e, 8'h00, 8'h5a, 0);
      cen <= 1;
      frame(8'h4c, 8'h00, 8'h69, 0);
      cmp(transfer_clock_pin_oe_n, 1);
      idl <= 1;
      frame(8'h4d, 8'h00, 8'h96, 0);
      // Three buffered frames with no read: gapless, the third overruns
      wr(scg_pkg::SCG_OFS_CTRL_C, 8'h0c, r);
      wr(scg_pkg::SCG_OFS_CTRL_A, 8'h41, r);
      for (int i = 1; i <= 3; i++) begin
         while (!irq_data_empty) @(posedge aclk);
         wr(scg_pkg::SCG_OFS_DATA, 32'h11 * i, r);
      end
      while (!irq_tx_complete) @(posedge aclk);
      rd(scg_pkg::SCG_OFS_CTRL_A, q, r);
      cmp(q, 32'he9);
      rd(scg_pkg::SCG_OFS_DATA, q, r);
      cmp(q, 32'h11);
      rd(scg_pkg::SCG_OFS_DATA, q, r);
      cmp(q, 32'h22);
      end_of_test();
   end
endmodule
`default_nettype wire
